// ==== include/rpq_params.svh ====
// Purpose: Named constants for the relay pulse qualifier
// Assumes: 20 MHz clock, byte-addressed classic Wishbone slave
// Notes: Alternate fixed-mode profile is 1 ms qualify, 30 ms pulse
`ifndef RPQ_PARAMS_SVH
`define RPQ_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define RPQ_CLK_KHZ 20000
`define RPQ_QUAL_MS 15
`define RPQ_MAX_MS 150
// Exact at 20 MHz, so least and longest rounding agree
`define RPQ_QUAL_CYC (`RPQ_QUAL_MS * `RPQ_CLK_KHZ)
`define RPQ_MAX_CYC (`RPQ_MAX_MS * `RPQ_CLK_KHZ)
`define RPQ_FOLLOW 1'b1

// ****************************************
// Register map
// ****************************************
`define RPQ_OFF_CTRL 8'h00
`define RPQ_OFF_STATUS 8'h04
`define RPQ_OFF_COUNT 8'h08
`define RPQ_CTRL_EN_BIT 0
`define RPQ_CTRL_RST 1'h1
`define RPQ_ST_OPEN_OUT 0
`define RPQ_ST_CLOSE_OUT 1
`define RPQ_ST_OPEN_REQ 2
`define RPQ_ST_CLOSE_REQ 3
`define RPQ_ST_GATE 4
`define RPQ_ST_OPEN_QB 5
`define RPQ_ST_CLOSE_QB 6
`define RPQ_ST_STATE_LSB 8
`define RPQ_CNT_OPEN_LSB 0
`define RPQ_CNT_CLOSE_LSB 8
`define RPQ_CNT_REF_LSB 16

`endif

// ==== include/rpq_pkg.sv ====
// Purpose: Types shared by the relay pulse qualifier modules
// Assumes: Counts fit 22 bits at the default timing
// Notes: States are binary coded
package rpq_pkg;
   typedef logic [21:0] rpq_cnt_t;
   typedef logic [7:0] rpq_evt_t;
   typedef enum logic [2:0] {
      RPQ_IDLE = 3'b000,
      RPQ_DRV_OPEN = 3'b001,
      RPQ_DRV_CLOSE = 3'b010,
      RPQ_HOLD_OPEN = 3'b011,
      RPQ_HOLD_CLOSE = 3'b100
   } rpq_state_e;
endpackage

// ==== logic/rpq_qual.sv ====
// Purpose: Qualifies one request input by its high time
// Assumes: Input synchronous to mclk_i
// Notes: Fires once per high period, so it is edge-like
`timescale 1ns/1ps
module rpq_qual import rpq_pkg::*; #(
   parameter int QUAL_CYC = 1
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Request and result
   input wire logic req_i,
   output logic fire_o,
   output logic busy_o
);
   rpq_cnt_t cnt;
   rpq_cnt_t next_cnt;

   // Saturating high-time counter, cleared whenever input is low
   always_comb begin
      next_cnt = cnt;
      if (!req_i) begin
         next_cnt = '0;
      end else if (cnt != rpq_cnt_t'(QUAL_CYC)) begin
         next_cnt = cnt + rpq_cnt_t'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Fire in the cycle the high time reaches the qualify count
   assign fire_o = req_i && (cnt == rpq_cnt_t'(QUAL_CYC - 1));
   assign busy_o = req_i && !fire_o && (cnt != rpq_cnt_t'(QUAL_CYC));
endmodule

// ==== logic/rpq_timer.sv ====
// Purpose: Output pulse width timer
// Assumes: start_i is a one-cycle pulse
// Notes: done_o rises in the last cycle of a full-width pulse and holds until restart
`timescale 1ns/1ps
module rpq_timer import rpq_pkg::*; #(
   parameter int MAX_CYC = 1
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Control and result
   input wire logic start_i,
   input wire logic run_i,
   output logic done_o
);
   rpq_cnt_t cnt;
   rpq_cnt_t next_cnt;

   // Restart on start, count while the pulse runs
   always_comb begin
      next_cnt = cnt;
      if (start_i) begin
         next_cnt = '0;
      end else if (run_i && !done_o) begin
         next_cnt = cnt + rpq_cnt_t'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign done_o = (cnt == rpq_cnt_t'(MAX_CYC - 1));
endmodule

// ==== logic/rpq_top.sv ====
// Purpose: Two-channel relay coil pulse qualifier and timer
// Assumes: Request, enable and lockout inputs are synchronous
// Notes: Registers over classic Wishbone, one-wait-state ack
`timescale 1ns/1ps
`include "rpq_params.svh"

// How it works
// - Requests shorter than qualify time are ignored
// - Requests held past qualify time are valid
// - Follow mode: output tracks input, capped
// - Fixed mode: output full maximum width unless the gate drops
// - Edge triggered; stuck-high input pulses once
// - Enable low ends pulse, blocks new ones
// - Both qualifying together gives no pulse
// - Follow: other input high blocks qualification
// - Fixed: other channel refused while first busy
// - Short noise on idle input has no effect
// - Supply lockout holds both outputs off
// - Separate open and close channels
module rpq_top import rpq_pkg::*; #(
   parameter int QUAL_CYC = `RPQ_QUAL_CYC,
   parameter int MAX_CYC = `RPQ_MAX_CYC,
   parameter bit FOLLOW_MODE = `RPQ_FOLLOW
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Controller requests and gating
   input wire logic open_req_i,
   input wire logic close_req_i,
   input wire logic enable_i,
   input wire logic supply_lockout_i,
   // Coil drives
   output logic coil_open_o,
   output logic coil_close_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic rpq_hit(input logic [7:0] adr, input logic [7:0] off);
      rpq_hit = (adr[7:2] == off[7:2]);
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   rpq_state_e state;
   rpq_state_e next_state;
   logic next_coil_open;
   logic next_coil_close;
   logic ctrl_en;
   logic next_ctrl_en;
   rpq_evt_t cnt_open;
   rpq_evt_t cnt_close;
   rpq_evt_t cnt_ref;
   rpq_evt_t next_cnt_open;
   rpq_evt_t next_cnt_close;
   rpq_evt_t next_cnt_ref;
   logic next_ack;
   logic [31:0] next_dat;
   logic fire_open;
   logic fire_close;
   logic qbusy_open;
   logic qbusy_close;
   logic done;
   logic start;
   logic running;
   logic gate;
   logic served_open;
   logic served_close;
   logic refused;
   logic bus_req;
   logic bus_wr;

   // ****************************************
   // Qualifiers and timer
   // ****************************************
   // One qualifier per channel keeps the channels independent
   rpq_qual #(.QUAL_CYC(QUAL_CYC)) u_qual_open (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .req_i(open_req_i),
      .fire_o(fire_open),
      .busy_o(qbusy_open)
   );

   rpq_qual #(.QUAL_CYC(QUAL_CYC)) u_qual_close (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .req_i(close_req_i),
      .fire_o(fire_close),
      .busy_o(qbusy_close)
   );

   // Only one coil can ever drive, so one shared timer suffices
   rpq_timer #(.MAX_CYC(MAX_CYC)) u_timer (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .start_i(start),
      .run_i(running),
      .done_o(done)
   );

   // ****************************************
   // Pulse sequencer
   // ****************************************
   // Pin enable, lockout and software enable all gate the drive
   assign gate = enable_i && !supply_lockout_i && ctrl_en;
   assign running = (state == RPQ_DRV_OPEN) || (state == RPQ_DRV_CLOSE);

   // Next state; a refused fire is lost since qualifiers fire once
   always_comb begin
      next_state = state;
      start = 1'b0;
      served_open = 1'b0;
      served_close = 1'b0;
      refused = 1'b0;
      case (state)
         RPQ_IDLE: begin
            if (!gate) begin
               refused = fire_open || fire_close;
            end else if (fire_open && fire_close) begin
               refused = 1'b1;
            end else if (fire_open) begin
               if (FOLLOW_MODE && close_req_i) begin
                  refused = 1'b1;
               end else begin
                  next_state = RPQ_DRV_OPEN;
                  start = 1'b1;
                  served_open = 1'b1;
               end
            end else if (fire_close) begin
               if (FOLLOW_MODE && open_req_i) begin
                  refused = 1'b1;
               end else begin
                  next_state = RPQ_DRV_CLOSE;
                  start = 1'b1;
                  served_close = 1'b1;
               end
            end
         end
         RPQ_DRV_OPEN: begin
            refused = fire_close;
            if (!gate) begin
               next_state = RPQ_IDLE;
            end else if (done || (FOLLOW_MODE && !open_req_i)) begin
               // Cap at full width; stay parked while input stays high
               next_state = open_req_i ? RPQ_HOLD_OPEN : RPQ_IDLE;
            end
         end
         RPQ_DRV_CLOSE: begin
            refused = fire_open;
            if (!gate) begin
               next_state = RPQ_IDLE;
            end else if (done || (FOLLOW_MODE && !close_req_i)) begin
               next_state = close_req_i ? RPQ_HOLD_CLOSE : RPQ_IDLE;
            end
         end
         RPQ_HOLD_OPEN: begin
            refused = fire_close;
            if (!open_req_i || !gate) begin
               next_state = RPQ_IDLE;
            end
         end
         RPQ_HOLD_CLOSE: begin
            refused = fire_open;
            if (!close_req_i || !gate) begin
               next_state = RPQ_IDLE;
            end
         end
         default: begin
            next_state = RPQ_IDLE;
         end
      endcase
      // Outputs follow the next state so they sit on flops
      next_coil_open = (next_state == RPQ_DRV_OPEN);
      next_coil_close = (next_state == RPQ_DRV_CLOSE);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= RPQ_IDLE;
         coil_open_o <= 1'b0;
         coil_close_o <= 1'b0;
      end else begin
         state <= next_state;
         coil_open_o <= next_coil_open;
         coil_close_o <= next_coil_close;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;

   // Control, event counters and read data
   always_comb begin
      next_ctrl_en = ctrl_en;
      next_cnt_open = cnt_open;
      next_cnt_close = cnt_close;
      next_cnt_ref = cnt_ref;
      next_dat = wb_dat_o;
      if (bus_wr && rpq_hit(wb_adr_i, `RPQ_OFF_CTRL) && wb_sel_i[0]) begin
         next_ctrl_en = wb_dat_i[`RPQ_CTRL_EN_BIT];
      end
      // A write clears, but an event in the same cycle still counts
      if (bus_wr && rpq_hit(wb_adr_i, `RPQ_OFF_COUNT) && (wb_sel_i != 4'h0)) begin
         next_cnt_open = '0;
         next_cnt_close = '0;
         next_cnt_ref = '0;
      end
      next_cnt_open = next_cnt_open + rpq_evt_t'(served_open);
      next_cnt_close = next_cnt_close + rpq_evt_t'(served_close);
      next_cnt_ref = next_cnt_ref + rpq_evt_t'(refused);
      if (bus_req && !wb_we_i) begin
         next_dat = 32'h0000_0000;
         if (rpq_hit(wb_adr_i, `RPQ_OFF_CTRL)) begin
            next_dat[`RPQ_CTRL_EN_BIT] = ctrl_en;
         end else if (rpq_hit(wb_adr_i, `RPQ_OFF_STATUS)) begin
            next_dat[`RPQ_ST_OPEN_OUT] = coil_open_o;
            next_dat[`RPQ_ST_CLOSE_OUT] = coil_close_o;
            next_dat[`RPQ_ST_OPEN_REQ] = open_req_i;
            next_dat[`RPQ_ST_CLOSE_REQ] = close_req_i;
            next_dat[`RPQ_ST_GATE] = gate;
            next_dat[`RPQ_ST_OPEN_QB] = qbusy_open;
            next_dat[`RPQ_ST_CLOSE_QB] = qbusy_close;
            next_dat[`RPQ_ST_STATE_LSB +: 3] = state;
         end else if (rpq_hit(wb_adr_i, `RPQ_OFF_COUNT)) begin
            next_dat[`RPQ_CNT_OPEN_LSB +: 8] = cnt_open;
            next_dat[`RPQ_CNT_CLOSE_LSB +: 8] = cnt_close;
            next_dat[`RPQ_CNT_REF_LSB +: 8] = cnt_ref;
         end
      end
      // Unmapped addresses still ack, reading zero
      next_ack = bus_req;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_en <= `RPQ_CTRL_RST;
         cnt_open <= '0;
         cnt_close <= '0;
         cnt_ref <= '0;
         wb_dat_o <= 32'h0000_0000;
         wb_ack_o <= 1'b0;
      end else begin
         ctrl_en <= next_ctrl_en;
         cnt_open <= next_cnt_open;
         cnt_close <= next_cnt_close;
         cnt_ref <= next_cnt_ref;
         wb_dat_o <= next_dat;
         wb_ack_o <= next_ack;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Both coils together would fight the latching relay
   never_both_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      !(coil_open_o && coil_close_o))
      else $error("both coil drives active");

   gate_off_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      !enable_i |=> !coil_open_o && !coil_close_o)
      else $error("drive survived enable low");

   lockout_off_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      supply_lockout_i |=> !coil_open_o && !coil_close_o)
      else $error("drive during supply lockout");

   start_cause_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      $rose(coil_open_o) |-> $past(fire_open) && $past(open_req_i))
      else $error("open pulse without qualification");

   short_ignore_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      (state == RPQ_IDLE) && !fire_open && !fire_close
      |=> !coil_open_o && !coil_close_o)
      else $error("pulse started without a qualified request");

   follow_end_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      FOLLOW_MODE && coil_close_o && !close_req_i |=> !coil_close_o)
      else $error("follow pulse outlived its input");

   fixed_width_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      !FOLLOW_MODE && $fell(coil_open_o) && $past(gate) |-> $past(done))
      else $error("fixed pulse ended early");

   max_cap_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      coil_open_o && done |=> !coil_open_o)
      else $error("pulse ran past maximum width");

   hold_refuse_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      (state == RPQ_HOLD_OPEN) && open_req_i && gate |=> !coil_close_o [*2])
      else $error("other channel served during hold");

   overlap_block_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      FOLLOW_MODE && (state == RPQ_IDLE) && fire_open && close_req_i
      |=> !coil_open_o && !coil_close_o)
      else $error("overlapping requests not blocked");

   open_follow_end_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      FOLLOW_MODE && coil_open_o && !open_req_i |=> !coil_open_o)
      else $error("follow open pulse outlived its input");

   close_cause_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      $rose(coil_close_o) |-> $past(fire_close) && $past(close_req_i))
      else $error("close pulse without qualification");

   busy_refuse_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      (state == RPQ_DRV_OPEN) && fire_close |=> !coil_close_o)
      else $error("idle channel served during a pulse");

   bus_ack_a: assert property (
      @(posedge mclk_i) disable iff (!arst_n_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule

// ==== tb/rpq_ctrl_model.sv ====
// Purpose: Meter controller model driving open and close requests
// Assumes: Requests change just after the rising clock edge
// Notes: Requests are driven levels, so low is the true idle value
`timescale 1ns/1ps
module rpq_ctrl_model (
   // Clock
   input wire logic mclk_i,
   // Requests
   output logic open_req_o,
   output logic close_req_o
);
   // ********
   // Stimulus
   // ********
   // Both requests idle low from time zero
   initial begin
      open_req_o = 1'b0;
      close_req_o = 1'b0;
   end
   // Open high lo samples; close high lc samples after dly
   task automatic burst(input int lo, input int dly, input int lc);
      for (int n = 0; n < lo || n < dly + lc; n++) begin
         @(posedge mclk_i);
         open_req_o <= (n < lo);
         close_req_o <= (n >= dly && n < dly + lc);
      end
      @(posedge mclk_i);
      open_req_o <= 1'b0;
      close_req_o <= 1'b0;
   endtask
endmodule

// ==== tb/test_relay_pulse_qualifier.sv ====
// Purpose: Self-checking bench for the relay pulse qualifier
// Assumes: Short timing, qualify 4 and pulse 20 cycles
// Notes: Follow and fixed instances see the same inputs
`timescale 1ns/1ps
module test_relay_pulse_qualifier;
   // *******
   // Signals
   // *******
   logic mclk_i, arst_n_i, enable_i, supply_lockout_i;
   logic open_req, close_req;
   logic coil_open, coil_close, cf_open, cf_close;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_ack_f;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, wb_dat_f, rd, rdf;
   logic [3:0] coils, prev, sel;
   int hi[4], rs[4], both, num_errors, compares, tno;
   // ******
   // Blocks
   // ******
   rpq_ctrl_model u_rpq_ctrl_model (.mclk_i(mclk_i), .open_req_o(open_req),
      .close_req_o(close_req));
   rpq_top #(.QUAL_CYC(4), .MAX_CYC(20), .FOLLOW_MODE(1'b1)) u_rpq_top (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .open_req_i(open_req),
      .close_req_i(close_req), .enable_i(enable_i), .supply_lockout_i(supply_lockout_i),
      .coil_open_o(coil_open), .coil_close_o(coil_close), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   // Fixed mode copy; its bus answers must match the follow copy
   rpq_top #(.QUAL_CYC(4), .MAX_CYC(20), .FOLLOW_MODE(1'b0)) u_rpq_top_fixed (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .open_req_i(open_req),
      .close_req_i(close_req), .enable_i(enable_i), .supply_lockout_i(supply_lockout_i),
      .coil_open_o(cf_open), .coil_close_o(cf_close), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_f), .wb_ack_o(wb_ack_f));
   // *******
   // Monitor
   // *******
   assign coils = {cf_close, cf_open, coil_close, coil_open};
   // High cycles, rising edges and overlap of both coils
   always @(posedge mclk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (coils[k] === 1'b1) hi[k]++;
         if (coils[k] === 1'b1 && prev[k] !== 1'b1) rs[k]++;
      end
      if ((coils[0] & coils[1]) | (coils[2] & coils[3])) both++;
      prev <= coils;
   end
   // Clear off the edge so the monitor update never races it
   task clr();
      @(posedge mclk_i);
      #1;
      for (int k = 0; k < 4; k++) begin
         hi[k] = 0;
         rs[k] = 0;
      end
      both = 0;
   endtask
   // *****
   // Tasks
   // *****
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task done();
      tno++;
      $display("Test %0d finished", tno);
   endtask
   task wrap_up();
      $display("Compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Classic single cycle; the wait is bounded so a dead slave ends the run
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         wrap_up();
      end
      rd = wb_dat_o;
      rdf = wb_dat_f;
      check(wb_ack_f, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // One request pattern, then expected rises per coil and fixed open width
   task scen(input int lo, dly, lc, r0, r1, r2, r3, h2);
      clr();
      u_rpq_ctrl_model.burst(lo, dly, lc);
      repeat (40) @(posedge mclk_i);
      check(rs[0], r0);
      check(rs[1], r1);
      check(rs[2], r2);
      check(rs[3], r3);
      check(both, 0);
      if (h2 >= 0) check(hi[2], h2);
      done();
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   initial begin
      {arst_n_i, supply_lockout_i, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, prev} = '0;
      sel = 4'hf;
      enable_i = 1'b1;
      {num_errors, compares, tno} = '0;
      repeat (12) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      wb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h1);
      wb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h10);
      wb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      // A control write without the low byte lane is ignored
      sel = 4'he;
      wb(1'b1, 8'h00, 32'h0);
      sel = 4'hf;
      wb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h1);
      done();
      wb(1'b1, 8'h08, 32'h0);
      scen(3, 0, 0, 0, 0, 0, 0, -1);
      scen(4, 0, 0, 1, 0, 1, 0, 20);
      wb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h1);
      check(rdf, 32'h1);
      scen(10, 0, 0, 1, 0, 1, 0, 20);
      check(hi[0], 7);
      scen(30, 0, 0, 1, 0, 1, 0, 20);
      check(hi[0], 20);
      wb(1'b1, 8'h08, 32'h0);
      scen(0, 0, 10, 0, 1, 0, 1, -1);
      wb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h100);
      check(rdf, 32'h100);
      scen(10, 0, 10, 0, 0, 0, 0, -1);
      scen(30, 2, 10, 0, 0, 1, 0, 20);
      scen(40, 25, 6, 1, 0, 1, 0, 20);
      scen(30, 10, 3, 1, 0, 1, 0, 20);
      // Enable dropped mid-pulse, then a request while still low
      clr();
      fork
         u_rpq_ctrl_model.burst(30, 0, 0);
         begin
            repeat (8) @(posedge mclk_i);
            enable_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
            #1;
            check({coil_open, cf_open}, 2'b00);
         end
      join
      u_rpq_ctrl_model.burst(10, 0, 0);
      repeat (30) @(posedge mclk_i);
      check(rs[0] + rs[2], 2);
      enable_i <= 1'b1;
      done();
      @(posedge mclk_i);
      supply_lockout_i <= 1'b1;
      scen(10, 0, 0, 0, 0, 0, 0, -1);
      supply_lockout_i <= 1'b0;
      wb(1'b1, 8'h00, 32'h0);
      scen(10, 0, 0, 0, 0, 0, 0, -1);
      wb(1'b1, 8'h00, 32'h1);
      scen(4, 0, 0, 1, 0, 1, 0, 20);
      // Input already high across a reset release pulses once
      clr();
      fork
         u_rpq_ctrl_model.burst(60, 0, 0);
         begin
            repeat (2) @(posedge mclk_i);
            arst_n_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
            arst_n_i <= 1'b1;
         end
      join
      repeat (10) @(posedge mclk_i);
      check(rs[0], 1);
      check(rs[2], 1);
      check(hi[0], 20);
      check(hi[2], 20);
      done();
      wrap_up();
   end
endmodule
